// >>> hdl/pdc_pkg.sv
package pdc_pkg;
    // Timing: 125 MHz fabric clock, least reset pulse rounded up to cycles
    localparam int CLK_PERIOD_NS = 8;
    localparam int RST_MIN_NS    = 10;
    localparam int RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC    = 64;
    localparam int LOCK_FILT     = 4;
    localparam int LOCK_REFS     = 16;
    localparam int PERIOD_TOL    = 1;
    // Link widths
    localparam int SEL_W         = 2;
    localparam int NUM_REF       = 4;
    localparam int STEP_W        = 3;
    localparam int NUM_OUT       = 5;
    localparam int MAX_RATIO     = 255;
    localparam int MAX_CLK0_MULT = 4;
    // Default counter settings
    localparam int DEF_N         = 1;
    localparam int DEF_M         = 4;
    localparam int DEF_O         = 2;
    localparam int DEF_CFBK      = 1;
    localparam logic [NUM_OUT-1:0][7:0] DEF_C = {8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
    // Register map
    localparam int REG_ADDR_W    = 4;
    localparam logic [REG_ADDR_W-1:0] OFS_CTRL     = 4'h0;
    localparam logic [REG_ADDR_W-1:0] OFS_STATUS   = 4'h4;
    localparam logic [REG_ADDR_W-1:0] OFS_INT_STAT = 4'h8;
    localparam logic [REG_ADDR_W-1:0] OFS_INT_MASK = 4'hC;
    localparam int CTRL_SEL_LSB  = 0;
    localparam int CTRL_RST_BIT  = 2;
    localparam int CTRL_STEP_LSB = 4;
    localparam int CTRL_APPLY    = 7;
    localparam int CTRL_OSEL_LSB = 8;
    localparam int ST_LOCK       = 0;
    localparam int ST_IN_RESET   = 1;
    localparam int ST_RATIO_OK   = 2;
    localparam int ST_CLK0_OK    = 3;
    localparam int ST_SEL_LSB    = 4;
    localparam int INT_W         = 2;
    localparam int INT_GAINED    = 0;
    localparam int INT_LOST      = 1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {FB_LOCAL, FB_CORE, FB_PAD} pdc_fb_mode_t;

    function automatic logic pdc_ratio_ok(int m, int o, int cfbk);
        return (m * o * cfbk) <= MAX_RATIO;
    endfunction : pdc_ratio_ok

    function automatic logic pdc_clk0_ok(int n, int m, int cfbk, int c0);
        return ((m * cfbk) % (n * c0) == 0) && ((m * cfbk) / (n * c0) <= MAX_CLK0_MULT);
    endfunction : pdc_clk0_ok
endpackage : pdc_pkg

// >>> hdl/pdc_pll_if.sv
`timescale 1ns/100ps
interface pdc_pll_if import pdc_pkg::*; ();
    logic [SEL_W-1:0]   ref_clock_select;
    logic               pll_reset_low;
    logic [STEP_W-1:0]  phase_step;
    logic [NUM_OUT-1:0] phase_out_select;
    logic               phase_apply_enable;
    logic               core_feedback_input;
    logic               pad_feedback_input;
    logic               lock_indicator;
    logic [NUM_OUT-1:0] out_clocks;

    modport device (
        input  ref_clock_select, pll_reset_low, phase_step, phase_out_select,
        input  phase_apply_enable, core_feedback_input, pad_feedback_input,
        output lock_indicator, out_clocks
    );
    modport fabric (
        output ref_clock_select, pll_reset_low, phase_step, phase_out_select,
        output phase_apply_enable, core_feedback_input, pad_feedback_input,
        input  lock_indicator, out_clocks
    );
endinterface : pdc_pll_if

// >>> hdl/pdc_sync.sv
`timescale 1ns/100ps
module pdc_sync import pdc_pkg::*; #(
    parameter int WIDTH = 1,
    parameter int FILT  = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    localparam int CW = $clog2(FILT + 1);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] q;
        logic [CW-1:0]    cnt;
    } pdc_sync_st_t;

    pdc_sync_st_t st_reg;
    pdc_sync_st_t st_next;

    // Value must hold FILT cycles before it passes; short pulses vanish
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
        if (st_reg.s2 == st_reg.q) begin
            st_next.cnt = '0;
        end else if (st_reg.cnt >= CW'(FILT - 1)) begin
            st_next.q   = st_reg.s2;
            st_next.cnt = '0;
        end else begin
            st_next.cnt = st_reg.cnt + CW'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.q;
endmodule : pdc_sync

// >>> hdl/pdc_device.sv
`timescale 1ns/100ps
module pdc_device import pdc_pkg::*; #(
    parameter int                       N_DIV    = DEF_N,
    parameter int                       M_MULT   = DEF_M,
    parameter int                       O_DIV    = DEF_O,
    parameter int                       CFBK_DIV = DEF_CFBK,
    parameter logic [NUM_OUT-1:0][7:0]  C_DIV    = DEF_C,
    parameter pdc_fb_mode_t             FB_MODE  = FB_LOCAL,
    parameter int                       PW       = 12
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    pdc_pll_if.device                lk,
    input  wire logic [NUM_REF-1:0]  ref_clock_inputs,
    output logic      [NUM_OUT-1:0]  global_clock_network
);
    localparam int LW = $clog2(LOCK_REFS + 1);
    localparam int AW = 34;
    localparam logic RATIO_OK = pdc_ratio_ok(M_MULT, O_DIV, CFBK_DIV);
    // Two toggles per output period per feedback count
    localparam logic signed [AW-1:0] INC = AW'(2 * M_MULT * CFBK_DIV);

    typedef struct packed {
        logic                            ref_prev;
        logic                            fb_prev;
        logic                            fb_seen;
        logic [PW-1:0]                   pcnt;
        logic [PW-1:0]                   period;
        logic [LW-1:0]                   stab;
        logic                            lock;
        logic [NUM_OUT-1:0]              clk;
        logic [NUM_OUT-1:0][STEP_W-1:0]  phase;
        logic [NUM_OUT-1:0][AW-1:0]      acc;
    } pdc_dev_st_t;

    pdc_dev_st_t        st_reg;
    pdc_dev_st_t        st_next;
    logic [NUM_REF-1:0] ref_sync;

    // Toggle threshold: half an output period in accumulator units
    function automatic logic signed [AW-1:0] dds_thr(logic [PW-1:0] p, logic [7:0] c);
        return $signed(AW'(p) * AW'(N_DIV) * AW'(c));
    endfunction : dds_thr

    function automatic logic near(logic [PW-1:0] a, logic [PW-1:0] b);
        return (a <= b + PW'(PERIOD_TOL)) && (a + PW'(PERIOD_TOL) >= b);
    endfunction : near

    pdc_sync #(
        .WIDTH (NUM_REF),
        .FILT  (1)
    ) u_ref_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (ref_clock_inputs),
        .dout    (ref_sync)
    );

    always_comb begin
        logic                   ref_now;
        logic                   fb_now;
        logic                   ref_rise;
        logic                   fb_ok;
        logic signed [AW-1:0]   a;
        logic signed [AW-1:0]   hstep;
        logic signed [STEP_W:0] dd;
        ref_now  = ref_sync[lk.ref_clock_select];
        fb_now   = (FB_MODE == FB_PAD) ? lk.pad_feedback_input : lk.core_feedback_input;
        ref_rise = ref_now & ~st_reg.ref_prev;
        fb_ok    = (FB_MODE == FB_LOCAL) || st_reg.fb_seen;
        hstep    = $signed(AW'(st_reg.period) * AW'(N_DIV));
        a        = '0;
        dd       = '0;
        st_next  = st_reg;
        st_next.ref_prev = ref_now;
        st_next.fb_prev  = fb_now;
        // Outside FB_LOCAL, feedback must be seen toggling before lock is claimed
        if (fb_now && !st_reg.fb_prev) begin
            st_next.fb_seen = 1'b1;
        end
        if (st_reg.pcnt != '1) begin
            st_next.pcnt = st_reg.pcnt + PW'(1);
        end
        // Lock: LOCK_REFS reference periods of matching length
        if (ref_rise) begin
            st_next.pcnt   = PW'(1);
            st_next.period = st_reg.pcnt;
            if (near(st_reg.pcnt, st_reg.period) && RATIO_OK && fb_ok) begin
                if (st_reg.stab != LW'(LOCK_REFS)) begin
                    st_next.stab = st_reg.stab + LW'(1);
                end
            end else begin
                st_next.stab = '0;
            end
        end else if (st_reg.pcnt > st_reg.period + PW'(PERIOD_TOL)) begin
            st_next.stab = '0;
        end
        st_next.lock = (st_next.stab == LW'(LOCK_REFS));
        // One accumulator per output; limited to aclk/2 output rate
        for (int i = 0; i < NUM_OUT; i++) begin
            if (lk.phase_apply_enable && lk.phase_out_select[i]) begin
                st_next.phase[i] = lk.phase_step;
            end
            if (st_reg.stab == '0) begin
                st_next.clk[i] = 1'b0;
                st_next.acc[i] = '0;
            end else begin
                a = $signed(st_reg.acc[i]) + INC;
                if (lk.phase_apply_enable && lk.phase_out_select[i]) begin
                    // Each step delays by half a PLL cycle
                    dd = $signed({1'b0, lk.phase_step}) - $signed({1'b0, st_reg.phase[i]});
                    a  = a - AW'(dd) * hstep;
                end
                if (a >= dds_thr(st_reg.period, C_DIV[i])) begin
                    a = a - dds_thr(st_reg.period, C_DIV[i]);
                    st_next.clk[i] = ~st_reg.clk[i];
                end
                st_next.acc[i] = a;
            end
        end
        if (!lk.pll_reset_low) begin
            st_next = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Consumers see lock as asynchronous; no phase relation promised
    assign lk.lock_indicator    = st_reg.lock;
    assign lk.out_clocks        = st_reg.clk;
    assign global_clock_network = st_reg.clk;
endmodule : pdc_device

// >>> hdl/pdc_fabric.sv
// Overview of operation
// - Four references, two-bit select picks one
// - Fabric holds reset while changing select
// - Reset low holds PLL, high enables
// - Release reset only with stable reference
// - Reset pulse at least 10 ns, power-up
// - Lock rises on lock, falls on loss
// - Lock is unsynchronised, pulses may be short
// - Step adds half PLL cycle each
// - Five-bit select picks stepped outputs
// - Apply enable high updates selected phases
// - Pre, feedback, post and output dividers
// - Frequency relations; M*O*Cfbk at most 255
// - Feedback input wired to clock output
// - Five output clocks to global network
// - First output at most 4x reference
`timescale 1ns/100ps
module pdc_fabric import pdc_pkg::*; #(
    parameter int                      N_DIV      = DEF_N,
    parameter int                      M_MULT     = DEF_M,
    parameter int                      O_DIV      = DEF_O,
    parameter int                      CFBK_DIV   = DEF_CFBK,
    parameter logic [NUM_OUT-1:0][7:0] C_DIV      = DEF_C,
    parameter int                      FB_OUT     = 0,
    parameter int                      SETTLE_LEN = SETTLE_CYC
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    pdc_pll_if.fabric                  lk,
    input  wire logic [REG_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [REG_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic                       irq
);
    localparam logic STAT_RATIO = pdc_ratio_ok(M_MULT, O_DIV, CFBK_DIV);
    localparam logic STAT_CLK0  = pdc_clk0_ok(N_DIV, M_MULT, CFBK_DIV, int'(C_DIV[0]));

    typedef enum logic [1:0] {H_RESET, H_SETTLE, H_RUN} pdc_hst_t;

    typedef struct packed {
        pdc_hst_t           st;
        logic [15:0]        cnt;
        logic               rst_n;
        logic               rst_req;
        logic [SEL_W-1:0]   sel_req;
        logic [SEL_W-1:0]   sel_cur;
        logic [STEP_W-1:0]  step;
        logic [NUM_OUT-1:0] osel;
        logic               apply;
        logic               fb;
        logic               lock_prev;
        logic [INT_W-1:0]   int_stat;
        logic [INT_W-1:0]   int_mask;
        logic               irq;
        logic               awready;
        logic               wready;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               arready;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
    } pdc_hst_st_t;

    pdc_hst_st_t st_reg;
    pdc_hst_st_t st_next;
    logic        lock_f;

    function automatic logic [31:0] byte_mask(logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction : byte_mask

    // Lock is asynchronous and may glitch: synchronise and filter
    pdc_sync #(
        .WIDTH (1),
        .FILT  (LOCK_FILT)
    ) u_lock_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (lk.lock_indicator),
        .dout    (lock_f)
    );

    always_comb begin
        logic [31:0]      m;
        logic [31:0]      w;
        logic [INT_W-1:0] ev;
        m       = byte_mask(s_axi_wstrb);
        w       = s_axi_wdata & m;
        ev      = '0;
        st_next = st_reg;
        st_next.apply   = 1'b0;
        st_next.fb      = lk.out_clocks[FB_OUT];
        st_next.awready = s_axi_awvalid && s_axi_wvalid && !st_reg.awready && !st_reg.bvalid;
        st_next.wready  = st_next.awready;
        st_next.arready = s_axi_arvalid && !st_reg.arready && !st_reg.rvalid;
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (st_reg.awready && s_axi_awvalid && s_axi_wvalid) begin
            st_next.bvalid = 1'b1;
            st_next.bresp  = RESP_OKAY;
            case (s_axi_awaddr)
                OFS_CTRL: begin
                    if (m[CTRL_SEL_LSB]) begin
                        st_next.sel_req = w[CTRL_SEL_LSB +: SEL_W];
                        st_next.rst_req = w[CTRL_RST_BIT];
                        st_next.step    = w[CTRL_STEP_LSB +: STEP_W];
                        st_next.apply   = w[CTRL_APPLY];
                    end
                    if (m[CTRL_OSEL_LSB]) begin
                        st_next.osel = w[CTRL_OSEL_LSB +: NUM_OUT];
                    end
                end
                OFS_INT_STAT: st_next.int_stat = st_reg.int_stat & ~w[INT_W-1:0];
                OFS_INT_MASK: begin
                    if (m[0]) begin
                        st_next.int_mask = w[INT_W-1:0];
                    end
                end
                OFS_STATUS: st_next.bresp = RESP_OKAY;
                default: st_next.bresp = RESP_SLVERR;
            endcase
        end
        if (st_reg.arready && s_axi_arvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = RESP_OKAY;
            st_next.rdata  = '0;
            case (s_axi_araddr)
                OFS_CTRL: begin
                    st_next.rdata[CTRL_SEL_LSB +: SEL_W]    = st_reg.sel_req;
                    st_next.rdata[CTRL_RST_BIT]             = st_reg.rst_req;
                    st_next.rdata[CTRL_STEP_LSB +: STEP_W]  = st_reg.step;
                    st_next.rdata[CTRL_OSEL_LSB +: NUM_OUT] = st_reg.osel;
                end
                OFS_STATUS: begin
                    st_next.rdata[ST_LOCK]              = lock_f;
                    st_next.rdata[ST_IN_RESET]          = ~st_reg.rst_n;
                    st_next.rdata[ST_RATIO_OK]          = STAT_RATIO;
                    st_next.rdata[ST_CLK0_OK]           = STAT_CLK0;
                    st_next.rdata[ST_SEL_LSB +: SEL_W]  = st_reg.sel_cur;
                end
                OFS_INT_STAT: st_next.rdata[INT_W-1:0] = st_reg.int_stat;
                OFS_INT_MASK: st_next.rdata[INT_W-1:0] = st_reg.int_mask;
                default: st_next.rresp = RESP_SLVERR;
            endcase
        end
        // Set after clear so an event in the clearing cycle survives
        st_next.lock_prev = lock_f;
        ev[INT_GAINED]    = lock_f & ~st_reg.lock_prev;
        ev[INT_LOST]      = ~lock_f & st_reg.lock_prev;
        st_next.int_stat  = st_next.int_stat | ev;
        st_next.irq       = |(st_next.int_stat & st_next.int_mask);
        // Reset sequencer: select only moves with reset held low
        case (st_reg.st)
            H_RESET: begin
                st_next.rst_n   = 1'b0;
                st_next.sel_cur = st_reg.sel_req;
                st_next.cnt     = st_reg.cnt + 16'h0001;
                if (st_reg.cnt >= 16'(RST_MIN_CYC - 1)) begin
                    st_next.st  = H_SETTLE;
                    st_next.cnt = '0;
                end
            end
            H_SETTLE: begin
                st_next.rst_n = 1'b0;
                st_next.cnt   = st_reg.cnt + 16'h0001;
                if (st_reg.cnt >= 16'(SETTLE_LEN - 1)) begin
                    st_next.st    = H_RUN;
                    st_next.rst_n = 1'b1;
                end
            end
            H_RUN: begin
                if (st_next.sel_req != st_reg.sel_cur || st_next.rst_req) begin
                    st_next.st      = H_RESET;
                    st_next.rst_n   = 1'b0;
                    st_next.rst_req = 1'b0;
                    st_next.cnt     = '0;
                end
            end
            default: st_next.st = H_RESET;
        endcase
    end

    // Reset value has reset low and the sequencer restarting: power-up reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign lk.ref_clock_select    = st_reg.sel_cur;
    assign lk.pll_reset_low       = st_reg.rst_n;
    assign lk.phase_step          = st_reg.step;
    assign lk.phase_out_select    = st_reg.osel;
    assign lk.phase_apply_enable  = st_reg.apply;
    assign lk.core_feedback_input = st_reg.fb;
    assign lk.pad_feedback_input  = st_reg.fb;
    assign s_axi_awready          = st_reg.awready;
    assign s_axi_wready           = st_reg.wready;
    assign s_axi_bvalid           = st_reg.bvalid;
    assign s_axi_bresp            = st_reg.bresp;
    assign s_axi_arready          = st_reg.arready;
    assign s_axi_rvalid           = st_reg.rvalid;
    assign s_axi_rdata            = st_reg.rdata;
    assign s_axi_rresp            = st_reg.rresp;
    assign irq                    = st_reg.irq;
endmodule : pdc_fabric

// >>> test/pdc_asserts.sv
`timescale 1ns/100ps
module pdc_asserts import pdc_pkg::*; #(
    parameter int FB_OUT     = 0,
    parameter int SETTLE_LEN = SETTLE_CYC
) (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic [SEL_W-1:0]   ref_clock_select,
    input wire logic               pll_reset_low,
    input wire logic [STEP_W-1:0]  phase_step,
    input wire logic [NUM_OUT-1:0] phase_out_select,
    input wire logic               phase_apply_enable,
    input wire logic               core_feedback_input,
    input wire logic               pad_feedback_input,
    input wire logic               lock_indicator,
    input wire logic [NUM_OUT-1:0] out_clocks
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Saturates so a long hold never wraps to a short count
    logic [7:0] low_cnt_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn || pll_reset_low) begin
            low_cnt_reg <= 8'h00;
        end else if (low_cnt_reg != 8'hFF) begin
            low_cnt_reg <= low_cnt_reg + 8'h01;
        end
    end
    sequence s_hold_low;
        !pll_reset_low [*3];
    endsequence
    a_reset_pulse_min: assert property ($fell(pll_reset_low) |-> s_hold_low)
        else $error("reset pulse too short");
    a_select_in_reset: assert property ($changed(ref_clock_select) |-> !pll_reset_low && !$past(pll_reset_low))
        else $error("select changed outside reset");
    a_release_settled: assert property ($rose(pll_reset_low) |-> low_cnt_reg >= SETTLE_LEN)
        else $error("reset released before settle");
    a_reset_kills_lock: assert property (!pll_reset_low |=> !lock_indicator)
        else $error("lock high while held in reset");
    a_reset_stops_out: assert property (!pll_reset_low |=> out_clocks == '0)
        else $error("outputs run while held in reset");
    a_lock_needs_run: assert property ($rose(lock_indicator) |-> $past(pll_reset_low, 8))
        else $error("lock rose too soon after reset");
    a_apply_one_cycle: assert property (phase_apply_enable |=> !phase_apply_enable)
        else $error("apply longer than one cycle");
    a_apply_fields_held: assert property (phase_apply_enable |=> $stable(phase_step) && $stable(phase_out_select))
        else $error("step fields moved at apply");
    a_feedback_copy: assert property (core_feedback_input == $past(out_clocks[FB_OUT]))
        else $error("core feedback not a copy of output");
    a_feedback_pair: assert property (pad_feedback_input == core_feedback_input)
        else $error("pad feedback differs from core");
endmodule : pdc_asserts

// >>> test/pll_dynamic_control_tb.sv
`timescale 1ns/100ps
module pll_dynamic_control_tb;
    import pdc_pkg::*;
    localparam int SL = 4;
    logic               aclk = 0;
    logic               aresetn = 0;
    logic [3:0]         awaddr = '0;
    logic [3:0]         araddr = '0;
    logic [31:0]        wdata = '0;
    logic [3:0]         wstrb = 4'hF;
    logic               awvalid = 0;
    logic               wvalid = 0;
    logic               bready = 0;
    logic               arvalid = 0;
    logic               rready = 0;
    wire logic          awready, wready, bvalid, arready, rvalid, irq;
    wire logic [1:0]    bresp, rresp;
    wire logic [31:0]   rdata;
    wire logic [4:0]    gcn;
    logic [NUM_REF-1:0] refs = '0;
    logic [3:0]         rc [NUM_REF] = '{default: '0};
    logic [2:0]         seen_step = '0;
    logic [4:0]         seen_osel = '0;
    logic               seen_low = 0;
    logic [4:0]         seen_clk = '0;
    logic [31:0]        d;
    int                 n_fail = 0;
    int                 compares = 0;
    pdc_pll_if lk();
    pdc_device pdc_device_i (.aclk(aclk), .aresetn(aresetn), .lk(lk), .ref_clock_inputs(refs),
        .global_clock_network(gcn));
    pdc_fabric #(.SETTLE_LEN(SL)) pdc_fabric_i (.aclk(aclk), .aresetn(aresetn), .lk(lk),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq));
    pdc_asserts #(.FB_OUT(0), .SETTLE_LEN(SL)) pdc_asserts_i (.aclk(aclk), .aresetn(aresetn),
        .ref_clock_select(lk.ref_clock_select), .pll_reset_low(lk.pll_reset_low),
        .phase_step(lk.phase_step), .phase_out_select(lk.phase_out_select),
        .phase_apply_enable(lk.phase_apply_enable), .core_feedback_input(lk.core_feedback_input),
        .pad_feedback_input(lk.pad_feedback_input), .lock_indicator(lk.lock_indicator),
        .out_clocks(lk.out_clocks));
    initial begin
        forever #4 aclk = ~aclk;
    end
    // Refs of 8..14 cycle periods stay slower than the sampler needs
    always @(posedge aclk) begin
        for (int i = 0; i < NUM_REF; i++) begin
            rc[i] <= (rc[i] == 4'(3 + i)) ? 4'h0 : rc[i] + 4'h1;
            if (rc[i] == 4'(3 + i)) refs[i] <= ~refs[i];
        end
        if (lk.phase_apply_enable === 1'b1) begin
            seen_step <= lk.phase_step;
            seen_osel <= lk.phase_out_select;
        end
        if (lk.pll_reset_low === 1'b0) seen_low <= 1'b1;
        if (aresetn) seen_clk <= seen_clk | gcn;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
        logic at = 0, wt = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            at |= (awready === 1'b1);
            wt |= (wready === 1'b1);
            if (at) awvalid <= 1'b0;
            if (wt) wvalid <= 1'b0;
        end while (!(at && wt));
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        v = rdata;
        chk({30'h0, rresp}, {30'h0, er});
    endtask : rd
    task automatic wait_lock();
        logic [31:0] s;
        // Old lock lingers through the filter: see it drop first
        do rd(OFS_STATUS, s, RESP_OKAY); while (s[ST_LOCK] !== 1'b0);
        do rd(OFS_STATUS, s, RESP_OKAY); while (s[ST_LOCK] !== 1'b1);
    endtask : wait_lock
    task automatic tally_and_finish();
        $display("mismatches %0d of %0d compares", n_fail, compares);
        if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        #400000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_INT_MASK, d, RESP_OKAY);
        chk(d, 32'h0);
        rd(4'h2, d, RESP_SLVERR);
        chk(d, 32'h0);
        wr(4'h2, 32'h0000_00FF, RESP_SLVERR);
        wr(OFS_STATUS, 32'h0000_00FF, RESP_OKAY);
        wr(OFS_INT_MASK, 32'h0000_0003, RESP_OKAY);
        wait_lock();
        chk({27'h0, seen_clk}, 32'h0000_001F);
        wr(OFS_INT_STAT, 32'h0000_0003, RESP_OKAY);
        // Each reference in turn, via a reset request
        for (int s = 0; s < NUM_REF; s++) begin
            @(posedge aclk);
            seen_low <= 1'b0;
            wr(OFS_CTRL, 32'(s) | 32'h0000_0004, RESP_OKAY);
            wait_lock();
            chk({31'h0, seen_low}, 32'h1);
            rd(OFS_STATUS, d, RESP_OKAY);
            chk(d & 32'h0000_003F, 32'h0000_000D | (32'(s) << ST_SEL_LSB));
            rd(OFS_INT_STAT, d, RESP_OKAY);
            chk(d & 32'h0000_0003, 32'h0000_0003);
            chk({31'h0, irq}, 32'h1);
            wr(OFS_INT_STAT, 32'h0000_0003, RESP_OKAY);
            rd(OFS_INT_STAT, d, RESP_OKAY);
            chk(d & 32'h0000_0003, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        wr(OFS_INT_MASK, 32'h0000_0000, RESP_OKAY);
        wr(OFS_CTRL, 32'h0000_0007, RESP_OKAY);
        wait_lock();
        rd(OFS_INT_STAT, d, RESP_OKAY);
        chk(d & 32'h0000_0003, 32'h0000_0003);
        chk({31'h0, irq}, 32'h0);
        // Every step value with a walking output select
        for (int st = 0; st < 8; st++) begin
            wr(OFS_CTRL, 32'h0000_0083 | (32'(st) << 4) | (32'h1 << (8 + st % 5)), RESP_OKAY);
            repeat (2) @(negedge aclk);
            chk({29'h0, seen_step}, 32'(st));
            chk({27'h0, seen_osel}, 32'h1 << (st % 5));
            rd(OFS_CTRL, d, RESP_OKAY);
            chk(d & 32'h0000_1FFB, 32'h0000_0003 | (32'(st) << 4) | (32'h1 << (8 + st % 5)));
        end
        tally_and_finish();
    end
endmodule : pll_dynamic_control_tb
